// ---- hw/sset_pkg.sv ----
// constants and register map of the scrub and error tracking block
//
// Functional notes
// - Scrub interval timer counts down from a 32-bit reload value, reset 0x0001_0000.
// - Port A multiple bit error sets status bit 0 while its interrupt enable is set.
// - The multiple bit error flag stays set; any write to status clears it.
// - Scrub address steps up to a 15-bit limit (reset 0x6000), then restarts at zero.
// - Port A single bit errors increment a 16-bit count; upper bits read zero.
// - Any write to the single bit error count register clears the count.
// - Each timer expiry advances the scrub address, so reload sets cycles per address.
// - Interrupt enable is control bit 2, reset 0; clear means no flag.
// - Scrub enable is control bit 0, reset 1; scrubber runs only while set.
package sset_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // bus geometry
  localparam int SSET_AW = 8;
  localparam int SSET_DW = 32;

  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [SSET_AW-1:0] SSET_OFS_CTRL = 8'h00;
  localparam logic [SSET_AW-1:0] SSET_OFS_TALLY = 8'h04;
  localparam logic [SSET_AW-1:0] SSET_OFS_RELOAD = 8'h08;
  localparam logic [SSET_AW-1:0] SSET_OFS_STATUS = 8'h0C;
  localparam logic [SSET_AW-1:0] SSET_OFS_LIMIT = 8'h10;
  localparam logic [SSET_AW-1:0] SSET_OFS_EVT = 8'h28;
  localparam logic [SSET_AW-1:0] SSET_OFS_MASK = 8'h2C;

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int SSET_CTRL_SCRUB_BIT = 0;
  localparam int SSET_CTRL_IRQ_EN_BIT = 2;
  localparam int SSET_STATUS_MI_BIT = 0;
  localparam int SSET_EVT_W = 3;
  localparam int SSET_EVT_MBE = 0;
  localparam int SSET_EVT_SBE = 1;
  localparam int SSET_EVT_WRAP = 2;

  ////////////////////////////////////////////////////////////////////////////
  // widths and reset values
  localparam int SSET_LIMIT_W = 15;
  localparam int SSET_TALLY_W = 16;
  localparam logic [SSET_DW-1:0] SSET_RELOAD_RST = 32'h0001_0000;
  localparam logic [SSET_LIMIT_W-1:0] SSET_LIMIT_RST = 15'h6000;
  localparam logic SSET_SCRUB_EN_RST = 1'b1;
  localparam logic SSET_IRQ_EN_RST = 1'b0;
  localparam logic [SSET_TALLY_W-1:0] SSET_TALLY_MAX = 16'hFFFF;
  localparam logic [SSET_DW-1:0] SSET_MIN_RELOAD = 32'h0000_0004;

endpackage

// ---- hw/sset_timer.sv ----
// scrub interval countdown timer
module sset_timer
  import sset_pkg::*;
(
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  // control
  input wire logic i_run,
  input wire logic [sset_pkg::SSET_DW-1:0] i_reload,
  // status
  output logic o_expire
);
  import sset_pkg::*;

  typedef struct packed {
    logic [SSET_DW-1:0] count;
  } sset_timer_s;

  sset_timer_s s_q;
  sset_timer_s s_d;

  ////////////////////////////////////////////////////////////////////////////
  // a reload of n gives one expiry every n cycles; while idle the count is
  // parked at the reload so the first period after enabling is a full one
  always_comb begin
    s_d = s_q;
    o_expire = 1'b0;
    if (!i_run) begin
      s_d.count = i_reload;
    end else if (s_q.count <= 32'h0000_0001) begin
      o_expire = 1'b1;
      s_d.count = i_reload;
    end else begin
      s_d.count = s_q.count - 32'h0000_0001;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      s_q <= '{count: SSET_RELOAD_RST};
    end else begin
      s_q <= s_d;
    end
  end

endmodule

// ---- hw/sset_tally.sv ----
// saturating event counter with write clear
module sset_tally
  import sset_pkg::*;
(
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  // events
  input wire logic i_inc,
  input wire logic i_clr,
  // count
  output logic [sset_pkg::SSET_TALLY_W-1:0] o_count
);
  import sset_pkg::*;

  typedef struct packed {
    logic [SSET_TALLY_W-1:0] count;
  } sset_tally_s;

  sset_tally_s s_q;
  sset_tally_s s_d;
  logic [SSET_TALLY_W-1:0] base;

  ////////////////////////////////////////////////////////////////////////////
  // clear first, then count, so an error in the clearing cycle is kept;
  // saturation avoids a wrap that would hide a burst of errors
  always_comb begin
    s_d = s_q;
    base = i_clr ? '0 : s_q.count;
    s_d.count = base;
    if (i_inc && base != SSET_TALLY_MAX) begin
      s_d.count = base + 16'h0001;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_count = s_q.count;

endmodule

// ---- hw/sset_top.sv ----
// scrub interval, scrub address walk and port a error tracking registers
module sset_top
  import sset_pkg::*;
(
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  // register port
  input wire logic [sset_pkg::SSET_AW-1:0] i_addr,
  input wire logic [sset_pkg::SSET_DW-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [sset_pkg::SSET_DW-1:0] o_rdata,
  // correction logic strobes, port a reads
  input wire logic i_porta_sbe,
  input wire logic i_porta_mbe,
  // scrubber
  output logic o_scrub_en,
  output logic o_scrub_step,
  output logic [sset_pkg::SSET_LIMIT_W-1:0] o_scrub_addr,
  // interrupt
  output logic o_irq
);
  import sset_pkg::*;

  typedef struct packed {
    logic scrub_en;
    logic irq_en;
    logic [SSET_DW-1:0] reload;
    logic mi_flag;
    logic [SSET_LIMIT_W-1:0] limit;
    logic [SSET_LIMIT_W-1:0] addr;
    logic step;
    logic [SSET_EVT_W-1:0] evt;
    logic [SSET_EVT_W-1:0] mask;
    logic irq;
    logic [SSET_DW-1:0] rdata;
  } sset_top_s;

  sset_top_s s_q;
  sset_top_s s_d;

  logic expire;
  logic [SSET_TALLY_W-1:0] tally;
  logic wr_ctrl;
  logic wr_tally;
  logic wr_reload;
  logic wr_status;
  logic wr_limit;
  logic wr_mask;
  logic rd_evt;
  logic mbe_flagged;
  logic wrap;

  ////////////////////////////////////////////////////////////////////////////
  // address decode
  assign wr_ctrl = i_wr && i_addr == SSET_OFS_CTRL;
  assign wr_tally = i_wr && i_addr == SSET_OFS_TALLY;
  assign wr_reload = i_wr && i_addr == SSET_OFS_RELOAD;
  assign wr_status = i_wr && i_addr == SSET_OFS_STATUS;
  assign wr_limit = i_wr && i_addr == SSET_OFS_LIMIT;
  assign wr_mask = i_wr && i_addr == SSET_OFS_MASK;
  assign rd_evt = i_rd && i_addr == SSET_OFS_EVT;

  // only enabled errors reach the flag
  assign mbe_flagged = i_porta_mbe && s_q.irq_en;
  // a limit below the current address also wraps, so a shrunk limit takes hold
  assign wrap = s_q.addr >= s_q.limit;

  ////////////////////////////////////////////////////////////////////////////
  // interval timer and error count
  sset_timer u_timer (
    .i_clk_sys(i_clk_sys),
    .i_rstn(i_rstn),
    .i_run(s_q.scrub_en),
    .i_reload(s_q.reload),
    .o_expire(expire)
  );

  sset_tally u_tally (
    .i_clk_sys(i_clk_sys),
    .i_rstn(i_rstn),
    .i_inc(i_porta_sbe),
    .i_clr(wr_tally),
    .o_count(tally)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    s_d = s_q;
    s_d.step = 1'b0;
    s_d.rdata = '0;

    // register writes
    if (wr_ctrl) begin
      s_d.scrub_en = i_wdata[SSET_CTRL_SCRUB_BIT];
      s_d.irq_en = i_wdata[SSET_CTRL_IRQ_EN_BIT];
    end
    if (wr_reload) begin
      s_d.reload = i_wdata;
    end
    if (wr_limit) begin
      s_d.limit = i_wdata[SSET_LIMIT_W-1:0];
    end
    if (wr_mask) begin
      s_d.mask = i_wdata[SSET_EVT_W-1:0];
    end

    // flag: any write clears, a new error in the same cycle wins
    if (wr_status) begin
      s_d.mi_flag = 1'b0;
    end
    if (mbe_flagged) begin
      s_d.mi_flag = 1'b1;
    end

    // scrub walk, one address per timer expiry
    if (expire) begin
      s_d.step = 1'b1;
      s_d.addr = wrap ? '0 : s_q.addr + 15'h0001;
    end

    // sticky events, cleared by reading them, set wins
    if (rd_evt) begin
      s_d.evt = '0;
    end
    if (i_porta_mbe) begin
      s_d.evt[SSET_EVT_MBE] = 1'b1;
    end
    if (i_porta_sbe) begin
      s_d.evt[SSET_EVT_SBE] = 1'b1;
    end
    if (expire && wrap) begin
      s_d.evt[SSET_EVT_WRAP] = 1'b1;
    end

    // one request line for the flag and the unmasked events
    s_d.irq = s_d.mi_flag || (|(s_d.evt & s_d.mask));

    // read data, unmapped offsets read zero
    if (i_rd) begin
      unique case (i_addr)
        SSET_OFS_CTRL: begin
          s_d.rdata[SSET_CTRL_SCRUB_BIT] = s_q.scrub_en;
          s_d.rdata[SSET_CTRL_IRQ_EN_BIT] = s_q.irq_en;
        end
        SSET_OFS_TALLY: begin
          s_d.rdata[SSET_TALLY_W-1:0] = tally;
        end
        SSET_OFS_RELOAD: begin
          s_d.rdata = s_q.reload;
        end
        SSET_OFS_STATUS: begin
          s_d.rdata[SSET_STATUS_MI_BIT] = s_q.mi_flag;
        end
        SSET_OFS_LIMIT: begin
          s_d.rdata[SSET_LIMIT_W-1:0] = s_q.limit;
        end
        SSET_OFS_EVT: begin
          s_d.rdata[SSET_EVT_W-1:0] = s_q.evt;
        end
        SSET_OFS_MASK: begin
          s_d.rdata[SSET_EVT_W-1:0] = s_q.mask;
        end
        default: begin
          s_d.rdata = '0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      s_q <= '{
        scrub_en: SSET_SCRUB_EN_RST,
        irq_en: SSET_IRQ_EN_RST,
        reload: SSET_RELOAD_RST,
        mi_flag: 1'b0,
        limit: SSET_LIMIT_RST,
        addr: '0,
        step: 1'b0,
        evt: '0,
        mask: '0,
        irq: 1'b0,
        rdata: '0
      };
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign o_rdata = s_q.rdata;
  assign o_scrub_en = s_q.scrub_en;
  assign o_scrub_step = s_q.step;
  assign o_scrub_addr = s_q.addr;
  assign o_irq = s_q.irq;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_reload_reads_back: assert property (
    @(posedge i_clk_sys) disable iff (!i_rstn)
    i_rd && i_addr == SSET_OFS_RELOAD |=> o_rdata == $past(s_q.reload)
  ) else $error("reload register read back wrong");

  a_period_four: assert property (
    @(posedge i_clk_sys) disable iff (!i_rstn)
    expire && s_q.reload == SSET_MIN_RELOAD && !wr_reload && !wr_ctrl
      ##1 (s_q.scrub_en && !wr_reload && !wr_ctrl)[*4]
      |-> expire
  ) else $error("timer period differs from reload");

  a_period_no_early: assert property (
    @(posedge i_clk_sys) disable iff (!i_rstn)
    expire && s_q.reload == SSET_MIN_RELOAD && s_q.scrub_en
      |=> !expire [*3]
  ) else $error("timer expired before reload count");

  a_mi_sets: assert property (
    @(posedge i_clk_sys) disable iff (!i_rstn)
    i_porta_mbe && s_q.irq_en |=> s_q.mi_flag && o_irq
  ) else $error("enabled multi error did not set flag");

  a_mi_needs_enable: assert property (
    @(posedge i_clk_sys) disable iff (!i_rstn)
    $rose(s_q.mi_flag) |-> $past(i_porta_mbe) && $past(s_q.irq_en)
  ) else $error("flag set without enabled multi error");

  a_mi_sticky: assert property (
    @(posedge i_clk_sys) disable iff (!i_rstn)
    s_q.mi_flag && !wr_status |=> s_q.mi_flag
  ) else $error("flag dropped without a write");

  a_mi_write_clear: assert property (
    @(posedge i_clk_sys) disable iff (!i_rstn)
    wr_status && !mbe_flagged |=> !s_q.mi_flag
  ) else $error("status write did not clear flag");

  a_irq_follows_mi: assert property (
    @(posedge i_clk_sys) disable iff (!i_rstn)
    s_q.mi_flag |-> o_irq
  ) else $error("irq low while flag set");

  a_tally_counts: assert property (
    @(posedge i_clk_sys) disable iff (!i_rstn)
    i_porta_sbe && !wr_tally && tally != SSET_TALLY_MAX
      |=> tally == $past(tally) + 16'h0001
  ) else $error("single error count did not increment");

  a_tally_upper_zero: assert property (
    @(posedge i_clk_sys) disable iff (!i_rstn)
    i_rd && i_addr == SSET_OFS_TALLY
      |=> o_rdata[SSET_DW-1:SSET_TALLY_W] == '0 && o_rdata[SSET_TALLY_W-1:0] == $past(tally)
  ) else $error("count register read wrong");

  a_tally_clears: assert property (
    @(posedge i_clk_sys) disable iff (!i_rstn)
    wr_tally |=> tally == {{(SSET_TALLY_W-1){1'b0}}, $past(i_porta_sbe)}
  ) else $error("count write did not clear");

  a_addr_steps: assert property (
    @(posedge i_clk_sys) disable iff (!i_rstn)
    expire && !wrap |=> o_scrub_step && o_scrub_addr == $past(s_q.addr) + 15'h0001
  ) else $error("scrub address did not step");

  a_addr_wraps: assert property (
    @(posedge i_clk_sys) disable iff (!i_rstn)
    expire && wrap |=> o_scrub_addr == '0 && s_q.evt[SSET_EVT_WRAP]
  ) else $error("scrub address did not wrap");

  a_scrub_halts: assert property (
    @(posedge i_clk_sys) disable iff (!i_rstn)
    !s_q.scrub_en |-> !expire ##1 $stable(o_scrub_addr)
  ) else $error("scrub ran while disabled");

  a_ctrl_reads_back: assert property (
    @(posedge i_clk_sys) disable iff (!i_rstn)
    i_rd && i_addr == SSET_OFS_CTRL
      |=> o_rdata[SSET_CTRL_SCRUB_BIT] == $past(s_q.scrub_en)
        && o_rdata[SSET_CTRL_IRQ_EN_BIT] == $past(s_q.irq_en)
  ) else $error("control register read back wrong");

  a_status_reads_flag: assert property (
    @(posedge i_clk_sys) disable iff (!i_rstn)
    i_rd && i_addr == SSET_OFS_STATUS
      |=> o_rdata[SSET_DW-1:SSET_STATUS_MI_BIT+1] == '0
        && o_rdata[SSET_STATUS_MI_BIT] == $past(s_q.mi_flag)
  ) else $error("status register read back wrong");

  a_limit_reads_back: assert property (
    @(posedge i_clk_sys) disable iff (!i_rstn)
    i_rd && i_addr == SSET_OFS_LIMIT
      |=> o_rdata[SSET_DW-1:SSET_LIMIT_W] == '0
        && o_rdata[SSET_LIMIT_W-1:0] == $past(s_q.limit)
  ) else $error("limit register read back wrong");

  // read data stand for one cycle only, so a stale word never looks fresh
  a_rdata_idle_zero: assert property (
    @(posedge i_clk_sys) disable iff (!i_rstn)
    !i_rd |=> o_rdata == '0
  ) else $error("read data not zero outside a read");

  a_scrub_en_on: assert property (
    @(posedge i_clk_sys) disable iff (!i_rstn)
    wr_ctrl && i_wdata[SSET_CTRL_SCRUB_BIT] |=> o_scrub_en
  ) else $error("scrub enable write did not set");

  a_scrub_en_off: assert property (
    @(posedge i_clk_sys) disable iff (!i_rstn)
    wr_ctrl && !i_wdata[SSET_CTRL_SCRUB_BIT] |=> !o_scrub_en
  ) else $error("scrub enable write did not clear");

  a_reload_write: assert property (
    @(posedge i_clk_sys) disable iff (!i_rstn)
    wr_reload |=> s_q.reload == $past(i_wdata)
  ) else $error("reload write not taken");

  a_mi_raises_irq: assert property (
    @(posedge i_clk_sys) disable iff (!i_rstn)
    $rose(s_q.mi_flag) |-> o_irq
  ) else $error("irq not raised with the flag");

  a_irq_has_cause: assert property (
    @(posedge i_clk_sys) disable iff (!i_rstn)
    o_irq |-> s_q.mi_flag || (|(s_q.evt & s_q.mask))
  ) else $error("irq high without a cause");

  // a legal reload never lets the timer expire twice in a row
  a_no_double_expiry: assert property (
    @(posedge i_clk_sys) disable iff (!i_rstn)
    expire && s_q.reload >= SSET_MIN_RELOAD |=> !expire
  ) else $error("timer expired on consecutive cycles");

  a_step_after_expiry: assert property (
    @(posedge i_clk_sys) disable iff (!i_rstn)
    o_scrub_step |-> $past(expire)
  ) else $error("scrub step without timer expiry");

  a_addr_holds: assert property (
    @(posedge i_clk_sys) disable iff (!i_rstn)
    !expire |=> $stable(o_scrub_addr)
  ) else $error("scrub address moved without expiry");

  a_tally_holds: assert property (
    @(posedge i_clk_sys) disable iff (!i_rstn)
    !i_porta_sbe && !wr_tally |=> $stable(tally)
  ) else $error("single error count moved without cause");

endmodule

// ---- tb/sset_err_src.sv ----
// partner model: port a correction logic that issues error strobes
module sset_err_src (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  // command from the bench
  input wire logic i_go,
  input wire logic [3:0] i_n_sbe,
  input wire logic i_mbe,
  // strobes to the block
  output logic o_sbe,
  output logic o_mbe
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [3:0] left_q;
  logic mbe_q;

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      left_q <= 4'h0;
      mbe_q <= 1'b0;
    end else begin
      mbe_q <= i_go & i_mbe;
      if (i_go) begin
        left_q <= i_n_sbe;
      end else if (left_q != 4'h0) begin
        left_q <= left_q - 4'h1;
      end
    end
  end

  // corrected words come back to back, the worst case for the counter
  assign o_sbe = (left_q != 4'h0);
  assign o_mbe = mbe_q;
endmodule

// ---- tb/tb_top.sv ----
// self-checking bench of the scrub and error tracking block
module tb_top
  import sset_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct {
    logic [7:0] a;
    logic [31:0] d;
    logic w;
    logic [31:0] e;
  } sset_row_s;

  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic go = 1'b0;
  logic [3:0] n_sbe = 4'h0;
  logic mbe_cmd = 1'b0;
  logic [31:0] rdata;
  logic sbe;
  logic mbe;
  logic scrub_en;
  logic step;
  logic [14:0] saddr;
  logic irq;
  logic [14:0] exp_a;
  int num_errors = 0;
  int n_checks = 0;
  int cyc = 0;
  int gap;

  sset_row_s rows [8] = '{
    '{SSET_OFS_CTRL, 32'h0, 1'b0, 32'h0000_0001},
    '{SSET_OFS_TALLY, 32'h0, 1'b0, 32'h0000_0000},
    '{SSET_OFS_RELOAD, 32'h0, 1'b0, 32'h0001_0000},
    '{SSET_OFS_STATUS, 32'h0, 1'b0, 32'h0000_0000},
    '{SSET_OFS_LIMIT, 32'h0, 1'b0, 32'h0000_6000},
    '{SSET_OFS_LIMIT, 32'hFFFF_FFFF, 1'b1, 32'h0000_7FFF},
    '{SSET_OFS_RELOAD, 32'h1234_5678, 1'b1, 32'h1234_5678},
    '{8'h3C, 32'hFFFF_FFFF, 1'b1, 32'h0000_0000}
  };

  always #12.5 clk = ~clk;

  sset_top dut_u (
    .i_clk_sys(clk),
    .i_rstn(rstn),
    .i_addr(addr),
    .i_wdata(wdata),
    .i_wr(wr),
    .i_rd(rd),
    .o_rdata(rdata),
    .i_porta_sbe(sbe),
    .i_porta_mbe(mbe),
    .o_scrub_en(scrub_en),
    .o_scrub_step(step),
    .o_scrub_addr(saddr),
    .o_irq(irq)
  );

  sset_err_src src_u (
    .i_clk_sys(clk),
    .i_rstn(rstn),
    .i_go(go),
    .i_n_sbe(n_sbe),
    .i_mbe(mbe_cmd),
    .o_sbe(sbe),
    .o_mbe(mbe)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask

  // read data stand one cycle only, so sample mid-cycle after the strobe edge
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(nm, e, rdata);
    @(posedge clk);
  endtask

  task automatic lvl(input string nm, input logic [1:0] e);
    @(negedge clk);
    chk(nm, {30'h0, e}, {30'h0, scrub_en, irq});
    @(posedge clk);
  endtask

  task automatic fire(input logic [3:0] n, input logic m);
    go <= 1'b1;
    n_sbe <= n;
    mbe_cmd <= m;
    @(posedge clk);
    go <= 1'b0;
    repeat (8) @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      close_out();
    end
  end

  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    lvl("reset_lvl", 2'b10);
    foreach (rows[i]) begin
      if (rows[i].w) begin
        wr_reg(rows[i].a, rows[i].d);
      end
      rd_chk("row", rows[i].a, rows[i].e);
    end
    // scrub walk with a short interval and a small wrap limit
    wr_reg(SSET_OFS_LIMIT, 32'h0000_0003);
    wr_reg(SSET_OFS_RELOAD, 32'h0000_0004);
    wr_reg(SSET_OFS_CTRL, 32'h0);
    repeat (6) @(posedge clk);
    @(negedge clk);
    chk("addr_frozen", 32'h0, {17'h0, saddr});
    lvl("scrub_off", 2'b00);
    wr_reg(SSET_OFS_CTRL, 32'h1);
    exp_a = 15'h0;
    for (int s = 0; s < 8; s++) begin
      gap = 0;
      do begin
        @(negedge clk);
        gap++;
      end while (step !== 1'b1 && gap < 40);
      exp_a = (exp_a >= 15'h3) ? 15'h0 : exp_a + 15'h1;
      chk("scrub_addr", {17'h0, exp_a}, {17'h0, saddr});
      if (s > 0) begin
        chk("step_gap", 32'd4, gap);
      end
    end
    @(posedge clk);
    wr_reg(SSET_OFS_CTRL, 32'h0);
    rd_chk("evt_wrap", SSET_OFS_EVT, 32'h4);
    // multi error with the enable clear
    fire(4'h0, 1'b1);
    lvl("irq_off", 2'b00);
    rd_chk("flag_off", SSET_OFS_STATUS, 32'h0);
    rd_chk("evt_mbe", SSET_OFS_EVT, 32'h1);
    rd_chk("evt_clr", SSET_OFS_EVT, 32'h0);
    // single errors, masked event interrupt
    wr_reg(SSET_OFS_MASK, 32'h2);
    fire(4'h5, 1'b0);
    lvl("irq_evt", 2'b01);
    rd_chk("tally", SSET_OFS_TALLY, 32'h5);
    wr_reg(SSET_OFS_MASK, 32'h0);
    lvl("irq_mask", 2'b00);
    rd_chk("evt_sbe", SSET_OFS_EVT, 32'h2);
    wr_reg(SSET_OFS_TALLY, 32'hDEAD_BEEF);
    rd_chk("tally_clr", SSET_OFS_TALLY, 32'h0);
    // clear in the same cycle as an error: the error still counts
    go <= 1'b1;
    n_sbe <= 4'h3;
    mbe_cmd <= 1'b0;
    @(posedge clk);
    go <= 1'b0;
    wr_reg(SSET_OFS_TALLY, 32'h0);
    repeat (4) @(posedge clk);
    rd_chk("tally_race", SSET_OFS_TALLY, 32'h3);
    // multi error with the enable set
    wr_reg(SSET_OFS_CTRL, 32'h4);
    fire(4'h0, 1'b1);
    lvl("irq_on", 2'b01);
    rd_chk("flag_set", SSET_OFS_STATUS, 32'h1);
    rd_chk("flag_hold", SSET_OFS_STATUS, 32'h1);
    wr_reg(SSET_OFS_STATUS, 32'h0);
    rd_chk("flag_clr", SSET_OFS_STATUS, 32'h0);
    lvl("irq_clr", 2'b00);
    // second reset in mid-run with the flag up
    fire(4'h0, 1'b1);
    rstn <= 1'b0;
    lvl("rst_lvl", 2'b10);
    rstn <= 1'b1;
    @(posedge clk);
    rd_chk("rst_ctrl", SSET_OFS_CTRL, 32'h1);
    rd_chk("rst_flag", SSET_OFS_STATUS, 32'h0);
    rd_chk("rst_reload", SSET_OFS_RELOAD, 32'h0001_0000);
    close_out();
  end
endmodule
